// ---- fpec_buf.sv ----
// holding buffer memory, one write port and one registered read port
// assumes both ports run on the controller clock
`timescale 1ns/1ps
module fpec_buf #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 64
) (
    // clock
    input wire logic clk,
    // write side
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    // read side
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rd_data_r;

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("fpec_buf: depth or width out of range");
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
        rd_data_r <= mem[rd_idx];
    end

    assign rd_data = rd_data_r;
endmodule

// ---- fpec_ctrl.sv ----
// flash program/erase sequencer with apb register slave
// assumes rst is power-on reset, sys_rst any other reset, both synchronous
// to ref_clk; the array macro follows arr_busy and reads the buffer
`timescale 1ns/1ps
module fpec_ctrl #(
    parameter int ROW_CYC = fpec_pkg::ROW_WRITE_CYC,
    parameter int WORD_CYC = fpec_pkg::ROW_WRITE_CYC,
    parameter int ERASE_CYC = fpec_pkg::ROW_WRITE_CYC,
    parameter int CNT_W = 17
) (
    // clock and resets
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // processor
    output logic cpu_stall,
    // flash array
    output logic arr_busy,
    output logic [3:0] arr_kind,
    output logic [23:0] arr_addr,
    input wire logic [5:0] arr_buf_idx,
    output logic [23:0] arr_buf_data
);
    localparam logic [CNT_W-1:0] ROW_N = CNT_W'(ROW_CYC);
    localparam logic [CNT_W-1:0] WORD_N = CNT_W'(WORD_CYC);
    localparam logic [CNT_W-1:0] ERASE_N = CNT_W'(ERASE_CYC);
    localparam int CYC_MAX = 2 ** CNT_W;

    if (ROW_CYC < 1 || WORD_CYC < 1 || ERASE_CYC < 1 || ROW_CYC >= CYC_MAX
            || WORD_CYC >= CYC_MAX || ERASE_CYC >= CYC_MAX) begin : g_chk
        $error("fpec_ctrl: operation cycle count out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    logic start_r, start_nxt, program_erase_enable_r, program_erase_enable_nxt, err_r, err_nxt;
    logic erase_r, erase_nxt, hold_r, arr_busy_r, arr_busy_nxt;
    logic [3:0] op_r, op_nxt;
    fpec_pkg::fpec_key_t key_r, key_nxt;
    fpec_pkg::fpec_kind_t kind_r, kind_nxt, kind_w;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [10:0] acc_r, acc_nxt;
    logic [23:0] adr_r, adr_nxt;
    logic [5:0] widx_r, widx_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [11:0] acc_sum;
    logic tick, acc, wr, go_try, go, bad, done, abort, buf_we, mapped;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    // stall the bus
    assign pready = !start_r && !hold_r;
    assign cpu_stall = start_r;
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite && mapped;
    assign mapped = paddr == fpec_pkg::OFF_CTL || paddr == fpec_pkg::OFF_KEY
        || paddr == fpec_pkg::OFF_BUF || paddr == fpec_pkg::OFF_ADR;
    assign pslverr = acc && !mapped;
    assign prdata = prdata_r;

    always_comb begin
        prdata_nxt = 32'h00000000;
        if (psel) begin
            case (paddr)
                fpec_pkg::OFF_CTL: prdata_nxt = {16'h0000, start_r, program_erase_enable_r, err_r,
                    6'h00, erase_r, 2'h0, op_r};
                fpec_pkg::OFF_KEY: prdata_nxt = 32'h00000000;
                fpec_pkg::OFF_BUF: prdata_nxt = {26'h0000000, widx_r};
                fpec_pkg::OFF_ADR: prdata_nxt = {8'h00, adr_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator tick from fractional divider
    // rc cycle rate
    // no second clock: 737 of every 2000 clocks carry one oscillator cycle
    assign acc_sum = {1'b0, acc_r} + fpec_pkg::FRC_RATE_10KHZ;
    assign tick = acc_sum >= fpec_pkg::REF_RATE_10KHZ;
    assign acc_nxt = tick ? 11'(acc_sum - fpec_pkg::REF_RATE_10KHZ) : acc_sum[10:0];

    ////////////////////////////////////////////////////////////////////////
    // unlock and start
    assign kind_w = fpec_pkg::decode(pwdata[fpec_pkg::BIT_ERASE], pwdata[3:0]);
    assign go_try = wr && paddr == fpec_pkg::OFF_CTL && pwdata[fpec_pkg::BIT_START];
    assign go = go_try && key_r == fpec_pkg::KS_ARMED && pwdata[fpec_pkg::BIT_PROGRAM_ERASE_ENABLE]
        && kind_w != fpec_pkg::K_BAD && !sys_rst;
    assign bad = go_try && !go;
    assign abort = sys_rst && start_r;
    assign done = start_r && (cnt_r == '0 || (tick && cnt_r == CNT_W'(1)));

    always_comb begin
        key_nxt = key_r;
        if (wr) begin
            key_nxt = fpec_pkg::KS_IDLE;
            if (paddr == fpec_pkg::OFF_KEY) begin
                if (pwdata[7:0] == fpec_pkg::KEY_FIRST) begin
                    key_nxt = fpec_pkg::KS_HALF;
                end else if (pwdata[7:0] == fpec_pkg::KEY_SECOND
                        && key_r == fpec_pkg::KS_HALF) begin
                    key_nxt = fpec_pkg::KS_ARMED;
                end
            end
        end
        if (sys_rst) begin
            key_nxt = fpec_pkg::KS_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register and sequencer
    always_comb begin
        start_nxt = start_r;
        program_erase_enable_nxt = program_erase_enable_r;
        err_nxt = err_r;
        erase_nxt = erase_r;
        op_nxt = op_r;
        kind_nxt = kind_r;
        cnt_nxt = cnt_r;
        arr_busy_nxt = arr_busy_r;
        adr_nxt = adr_r;
        if (wr && paddr == fpec_pkg::OFF_ADR) begin
            adr_nxt = pwdata[23:0];
        end
        if (wr && paddr == fpec_pkg::OFF_CTL) begin
            program_erase_enable_nxt = pwdata[fpec_pkg::BIT_PROGRAM_ERASE_ENABLE];
            err_nxt = pwdata[fpec_pkg::BIT_ERR];
            erase_nxt = pwdata[fpec_pkg::BIT_ERASE];
            op_nxt = pwdata[3:0];
        end
        if (go) begin
            start_nxt = 1'b1;
            kind_nxt = kind_w;
            arr_busy_nxt = kind_w != fpec_pkg::K_NONE;
            case (kind_w)
                fpec_pkg::K_ROW: cnt_nxt = ROW_N;
                fpec_pkg::K_WORD, fpec_pkg::K_CFG_PROG: cnt_nxt = WORD_N;
                fpec_pkg::K_NONE: cnt_nxt = '0;
                default: cnt_nxt = ERASE_N;
            endcase
        end else if (start_r && tick && cnt_r != '0) begin
            cnt_nxt = cnt_r - CNT_W'(1);
        end
        if (done || abort) begin
            start_nxt = 1'b0;
            arr_busy_nxt = 1'b0;
            cnt_nxt = '0;
        end
        if (done && !abort) begin
            err_nxt = 1'b0;
        end
        if (bad || abort) begin
            err_nxt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // holding buffer
    assign buf_we = wr && paddr == fpec_pkg::OFF_BUF;

    always_comb begin
        widx_nxt = widx_r;
        if (buf_we) begin
            widx_nxt = widx_r + 6'h01;
        end
        if (sys_rst || (done && kind_r == fpec_pkg::K_ROW)) begin
            widx_nxt = 6'h00;
        end
    end

    fpec_buf #(
        .WIDTH(fpec_pkg::INSTR_W),
        .DEPTH(fpec_pkg::BUF_DEPTH)
    ) u_buf (
        .clk(ref_clk),
        .wr_en(buf_we),
        .wr_idx(widx_r),
        .wr_data(pwdata[23:0]),
        .rd_idx(arr_buf_idx),
        .rd_data(arr_buf_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // array outputs
    assign arr_busy = arr_busy_r;
    assign arr_kind = kind_r;

    always_comb begin
        case (kind_r)
            fpec_pkg::K_PAGE:
                arr_addr = {adr_r[23:fpec_pkg::PAGE_ADR_BITS],
                    {fpec_pkg::PAGE_ADR_BITS{1'b0}}};
            fpec_pkg::K_ROW:
                arr_addr = {adr_r[23:fpec_pkg::ROW_ADR_BITS],
                    {fpec_pkg::ROW_ADR_BITS{1'b0}}};
            fpec_pkg::K_WORD: arr_addr = {adr_r[23:1], 1'b0};
            default: arr_addr = adr_r;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            start_r <= fpec_pkg::CTL_RST[fpec_pkg::BIT_START];
            program_erase_enable_r <= fpec_pkg::CTL_RST[fpec_pkg::BIT_PROGRAM_ERASE_ENABLE];
            err_r <= fpec_pkg::CTL_RST[fpec_pkg::BIT_ERR];
            erase_r <= fpec_pkg::CTL_RST[fpec_pkg::BIT_ERASE];
            op_r <= fpec_pkg::CTL_RST[3:0];
            key_r <= fpec_pkg::KS_IDLE;
            kind_r <= fpec_pkg::K_NONE;
            cnt_r <= '0;
            arr_busy_r <= 1'b0;
            hold_r <= 1'b0;
            acc_r <= 11'h000;
            adr_r <= fpec_pkg::ADR_RST;
            widx_r <= 6'h00;
            prdata_r <= 32'h00000000;
        end else begin
            start_r <= start_nxt;
            program_erase_enable_r <= program_erase_enable_nxt;
            err_r <= err_nxt;
            erase_r <= erase_nxt;
            op_r <= op_nxt;
            key_r <= key_nxt;
            kind_r <= kind_nxt;
            cnt_r <= cnt_nxt;
            arr_busy_r <= arr_busy_nxt;
            // one spare wait lets read data settle after completion
            hold_r <= start_r;
            acc_r <= acc_nxt;
            adr_r <= adr_nxt;
            widx_r <= widx_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [CNT_W-1:0] ticks_seen_r;
    always_ff @(posedge ref_clk) begin
        if (rst || go) begin
            ticks_seen_r <= '0;
        end else if (arr_busy_r && tick) begin
            ticks_seen_r <= ticks_seen_r + CNT_W'(1);
        end
    end

    // key history seen on the bus, kept apart from the key state machine
    logic first_seen_r, pair_seen_r;
    always_ff @(posedge ref_clk) begin
        if (rst || sys_rst) begin
            first_seen_r <= 1'b0;
            pair_seen_r <= 1'b0;
        end else if (wr) begin
            first_seen_r <= paddr == fpec_pkg::OFF_KEY && pwdata[7:0] == fpec_pkg::KEY_FIRST;
            pair_seen_r <= first_seen_r && paddr == fpec_pkg::OFF_KEY
                && pwdata[7:0] == fpec_pkg::KEY_SECOND;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_unlock;
        first_seen_r && wr && paddr == fpec_pkg::OFF_KEY
            && pwdata[7:0] == fpec_pkg::KEY_SECOND;
    endsequence

    a_stall_while_busy: assert property (start_r |-> !pready && cpu_stall)
        else $error("bus not stalled during operation");
    a_row_tick_count: assert property ($fell(arr_busy_r) && $past(kind_r) == fpec_pkg::K_ROW
        && !$past(sys_rst) |-> ticks_seen_r == ROW_N)
        else $error("row write did not last the set oscillator cycles");
    a_start_launches: assert property ($rose(start_r) |-> $past(go)
        && (arr_busy_r == (kind_r != fpec_pkg::K_NONE)))
        else $error("start bit rose without a launch");
    a_zero_keeps_start: assert property (start_r && !done && !abort |=> start_r)
        else $error("start bit cleared before completion");
    a_program_erase_enable_gates: assert property ($rose(start_r) |-> $past(pwdata[fpec_pkg::BIT_PROGRAM_ERASE_ENABLE]))
        else $error("operation started without write enable");
    a_bad_sets_err: assert property (bad |=> err_r && !start_r)
        else $error("refused start did not raise error");
    a_erase_kinds: assert property ($rose(start_r) && erase_r |-> kind_r inside
        {fpec_pkg::K_NONE, fpec_pkg::K_BULK, fpec_pkg::K_GEN, fpec_pkg::K_SEC,
         fpec_pkg::K_PAGE, fpec_pkg::K_CFG_ERASE})
        else $error("erase select gave a program kind");
    a_prog_kinds: assert property ($rose(start_r) && !erase_r |-> kind_r inside
        {fpec_pkg::K_NONE, fpec_pkg::K_WORD, fpec_pkg::K_ROW, fpec_pkg::K_CFG_PROG})
        else $error("program select gave an erase kind");
    a_unimpl_refused: assert property (go_try && kind_w == fpec_pkg::K_BAD |=> !start_r)
        else $error("unimplemented code started");
    a_key_reads_zero: assert property (psel && !pwrite && paddr == fpec_pkg::OFF_KEY
        ##1 psel && penable && paddr == fpec_pkg::OFF_KEY |-> prdata == 32'h00000000)
        else $error("key register read nonzero");
    a_unlock_needed: assert property (go |-> pair_seen_r)
        else $error("start accepted without unlock");
    a_unlock_arms: assert property (s_unlock |=> key_r == fpec_pkg::KS_ARMED
        || sys_rst || $past(sys_rst))
        else $error("key pair did not arm the start");
    a_intervene_cancel: assert property (key_r == fpec_pkg::KS_ARMED && wr
        && paddr != fpec_pkg::OFF_CTL |=> key_r != fpec_pkg::KS_ARMED)
        else $error("unlock survived an intervening write");
endmodule

// ---- fpec_pkg.sv ----
// constants and types of the flash program/erase controller
// assumes a single 20 MHz clock and an apb master that reaches the registers
// How it works
// - cpu held stalled until operation ends
// - operation timed in rc oscillator cycles
// - start bit launches, hardware clears it
// - start only set; written zero ignored
// - write enable gates program and erase
// - error flag on improper start/termination
// - erase select picks erase or program
// - erase codes decode to five erases
// - program codes decode to three programs
// - unimplemented codes never start operation
// - control bits cleared only by power-on
// - key register write-only, reads zero
// - key 55 then AA before start
// - 64-instruction holding buffer feeds row program
// - pages and rows aligned from zero
package fpec_pkg;
    localparam logic [11:0] OFF_CTL = 12'h000;
    localparam logic [11:0] OFF_KEY = 12'h004;
    localparam logic [11:0] OFF_BUF = 12'h008;
    localparam logic [11:0] OFF_ADR = 12'h00C;
    localparam int BIT_START = 15;
    localparam int BIT_PROGRAM_ERASE_ENABLE = 14;
    localparam int BIT_ERR = 13;
    localparam int BIT_ERASE = 6;
    localparam logic [15:0] CTL_RST = 16'h0000;
    localparam logic [23:0] ADR_RST = 24'h000000;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [3:0] OP_BULK = 4'hF;
    localparam logic [3:0] OP_GEN = 4'hD;
    localparam logic [3:0] OP_SEC = 4'hC;
    localparam logic [3:0] OP_PAGE = 4'h2;
    localparam logic [3:0] OP_WORD = 4'h3;
    localparam logic [3:0] OP_ROW = 4'h1;
    localparam logic [3:0] OP_CFG = 4'h0;
    localparam int ROW_WRITE_CYC = 11064;
    // rates in units of 10 kHz: 7.37 MHz oscillator, 20 MHz clock
    localparam logic [11:0] FRC_RATE_10KHZ = 12'h2E1;
    localparam logic [11:0] REF_RATE_10KHZ = 12'h7D0;
    localparam int BUF_DEPTH = 64;
    localparam int INSTR_W = 24;
    localparam int ROW_BYTES = 192;
    localparam int PAGE_BYTES = 1536;
    // three bytes per instruction, two address units per instruction
    localparam int ROW_ADR_BITS = $clog2(ROW_BYTES / 3 * 2);
    localparam int PAGE_ADR_BITS = $clog2(PAGE_BYTES / 3 * 2);

    typedef enum logic [3:0] {
        K_NONE, K_BULK, K_GEN, K_SEC, K_PAGE, K_CFG_ERASE,
        K_WORD, K_ROW, K_CFG_PROG, K_BAD
    } fpec_kind_t;

    typedef enum logic [1:0] {KS_IDLE, KS_HALF, KS_ARMED} fpec_key_t;

    function automatic fpec_kind_t decode(input logic erase, input logic [3:0] op);
        fpec_kind_t k;
        k = K_BAD;
        if (erase) begin
            case (op)
                OP_BULK: k = K_BULK;
                OP_GEN: k = K_GEN;
                OP_SEC: k = K_SEC;
                OP_PAGE: k = K_PAGE;
                OP_CFG: k = K_CFG_ERASE;
                OP_WORD, OP_ROW: k = K_NONE;
                default: k = K_BAD;
            endcase
        end else begin
            case (op)
                OP_WORD: k = K_WORD;
                OP_ROW: k = K_ROW;
                OP_CFG: k = K_CFG_PROG;
                OP_BULK, OP_GEN, OP_SEC, OP_PAGE: k = K_NONE;
                default: k = K_BAD;
            endcase
        end
        return k;
    endfunction
endpackage

// ---- fpec_tb.sv ----
// self-checking bench for the flash program/erase controller
// assumes fpec_pkg compiled first; short op counts keep the run brief
`timescale 1ns/1ps
module testbench;
logic ref_clk, rst, sys_rst, psel, penable, pwrite, pready, pslverr;
logic [11:0] paddr;
logic [31:0] pwdata, prdata;
logic cpu_stall, arr_busy;
logic [3:0] arr_kind;
logic [23:0] arr_addr, arr_buf_data;
logic [5:0] arr_buf_idx;
logic [33:0] exp_q[$];
logic [15:0] lfsr;
int error_cnt, num_checks;
localparam int OPCYC = 8;
////////////////////////////////////////////////////////////////////////
fpec_ctrl #(.ROW_CYC(OPCYC), .WORD_CYC(OPCYC), .ERASE_CYC(OPCYC)) dut (
    .ref_clk(ref_clk), .rst(rst), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_stall(cpu_stall), .arr_busy(arr_busy), .arr_kind(arr_kind),
    .arr_addr(arr_addr), .arr_buf_idx(arr_buf_idx), .arr_buf_data(arr_buf_data));
initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
end
////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
        error_cnt++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
// setup then access, held until pready is seen high at a falling edge, released after the next rising edge
task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] ed, input logic ee);
    logic rdy;
    exp_q.push_back({w, ee, ed});
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
        @(negedge ref_clk);
        rdy = pready;
        @(posedge ref_clk);
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0000_0000, 1'b0);
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, e, 1'b0);
endtask
task automatic unlock();
    wr(fpec_pkg::OFF_KEY, {24'h0, fpec_pkg::KEY_FIRST});
    wr(fpec_pkg::OFF_KEY, {24'h0, fpec_pkg::KEY_SECOND});
endtask
function automatic logic [15:0] step(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
endfunction
// expected array kind; 0 is a no-op code, F an unimplemented one
function automatic logic [3:0] xk(input logic e, input logic [3:0] op);
    if (e) begin
        case (op)
            fpec_pkg::OP_BULK: return 4'h1;
            fpec_pkg::OP_GEN: return 4'h2;
            fpec_pkg::OP_SEC: return 4'h3;
            fpec_pkg::OP_PAGE: return 4'h4;
            fpec_pkg::OP_CFG: return 4'h5;
            fpec_pkg::OP_WORD, fpec_pkg::OP_ROW: return 4'h0;
            default: return 4'hF;
        endcase
    end
    case (op)
        fpec_pkg::OP_WORD: return 4'h6;
        fpec_pkg::OP_ROW: return 4'h7;
        fpec_pkg::OP_CFG: return 4'h8;
        fpec_pkg::OP_BULK, fpec_pkg::OP_GEN, fpec_pkg::OP_SEC, fpec_pkg::OP_PAGE: return 4'h0;
        default: return 4'hF;
    endcase
endfunction
////////////////////////////////////////////////////////////////////////
// monitor: every completed transfer retires the oldest note
always @(negedge ref_clk) begin
    logic [33:0] n;
    if (!rst && psel && penable && pready) begin
        n = exp_q.pop_front();
        chk("pslverr", {31'h0, n[32]}, {31'h0, pslverr});
        if (!n[33])
            chk("prdata", n[31:0], prdata);
    end
end
initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
end
////////////////////////////////////////////////////////////////////////
initial begin
    logic [15:0] s;
    logic [3:0] k;
    logic [23:0] adr;
    logic [23:0] ent[3];
    int n;
    rst = 1'b1;
    sys_rst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    arr_buf_idx = 6'h00;
    lfsr = 16'h0043;
    error_cnt = 0;
    num_checks = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(fpec_pkg::OFF_CTL, 32'h0000_0000);
    rd(fpec_pkg::OFF_KEY, 32'h0000_0000);
    xfer(1'b0, 12'h010, 32'h0, 32'h0000_0000, 1'b1);
    // page erase then two rows, stall length scaled from oscillator ticks
    for (int r = 0; r < 3; r++) begin
        s = r == 0 ? 16'h4042 : 16'h4001;
        wr(fpec_pkg::OFF_CTL, {16'h0, s});
        unlock();
        wr(fpec_pkg::OFF_CTL, {16'h0, s | 16'h8000});
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (cpu_stall === 1'b1 && n < 200);
        chk("stall_in_range", 32'h1, {31'h0, n >= 19 && n <= 25});
        rd(fpec_pkg::OFF_CTL, {16'h0, s});
    end
    wr(fpec_pkg::OFF_CTL, 32'h0000_C001);
    rd(fpec_pkg::OFF_CTL, 32'h0000_6001);
    unlock();
    wr(fpec_pkg::OFF_ADR, 32'h0000_0000);
    wr(fpec_pkg::OFF_CTL, 32'h0000_C001);
    rd(fpec_pkg::OFF_CTL, 32'h0000_6001);
    wr(fpec_pkg::OFF_CTL, 32'h0000_0001);
    unlock();
    wr(fpec_pkg::OFF_CTL, 32'h0000_8001);
    rd(fpec_pkg::OFF_CTL, 32'h0000_2001);
    // abort by system reset keeps control bits, flags the error
    wr(fpec_pkg::OFF_CTL, 32'h0000_4001);
    unlock();
    wr(fpec_pkg::OFF_CTL, 32'h0000_C001);
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(fpec_pkg::OFF_CTL, 32'h0000_6001);
    // holding buffer fill with random entries
    for (int i = 0; i < 3; i++) begin
        lfsr = step(lfsr);
        s = step(lfsr);
        ent[i] = {lfsr[7:0], s};
        lfsr = s;
        wr(fpec_pkg::OFF_BUF, {8'h00, ent[i]});
    end
    rd(fpec_pkg::OFF_BUF, 32'h0000_0003);
    @(posedge ref_clk);
    arr_buf_idx <= 6'h01;
    repeat (2) @(posedge ref_clk);
    #1 chk("arr_buf_data", {8'h00, ent[1]}, {8'h00, arr_buf_data});
    lfsr = step(lfsr);
    adr = {lfsr[7:0], step(lfsr)};
    wr(fpec_pkg::OFF_ADR, {8'h00, adr});
    rd(fpec_pkg::OFF_ADR, {8'h00, adr});
    // every erase select and operation code
    for (int i = 0; i < 32; i++) begin
        k = xk(i[4], i[3:0]);
        s = 16'h4000 | {9'h0, i[4], 2'b00, i[3:0]};
        wr(fpec_pkg::OFF_CTL, {16'h0, s});
        unlock();
        wr(fpec_pkg::OFF_CTL, {16'h0, s | 16'h8000});
        // two idle cycles after the start write
        repeat (2) @(posedge ref_clk);
        #1 chk("arr_busy", {31'h0, k != 4'h0 && k != 4'hF}, {31'h0, arr_busy});
        if (k != 4'h0 && k != 4'hF) begin
            chk("arr_kind", {28'h0, k}, {28'h0, arr_kind});
            chk("cpu_stall", 32'h1, {31'h0, cpu_stall});
            if (k == 4'h4)
                chk("page_addr", {8'h0, adr & 24'hFFFC00}, {8'h0, arr_addr});
            if (k == 4'h7)
                chk("row_addr", {8'h0, adr & 24'hFFFF80}, {8'h0, arr_addr});
            if (k == 4'h6)
                chk("word_addr", {8'h0, adr & 24'hFFFFFE}, {8'h0, arr_addr});
        end
        rd(fpec_pkg::OFF_CTL, {16'h0, s | (k == 4'hF ? 16'h2000 : 16'h0000)});
    end
    // power-on reset alone clears the control bits
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(fpec_pkg::OFF_CTL, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    report_and_stop();
end
endmodule
